// >>> logic/smc_sleep_ctrl.sv
// Purpose: Sleep entry, clock gating, wake qualification and resume sequencing
// Assumes: Core raises halt_exec_i one cycle for each halt opcode; inputs synchronous
// Notes:   Gate enables are registered so they change only on clock edges
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Halt opcode sleeps only while the arm bit is set.
// R2: Three-bit mode field selects one of six sleep modes.
// R3: Interrupt wake holds core four cycles past oscillator start-up, then resumes.
// R4: Register file and SRAM stay unchanged across sleep.
// R5: Reset during sleep wakes device and restarts from reset vector.
// R6: Mode 000 idle gates only core and flash clocks; here idle also stops the timer osc unless async select is set.
// R7: Idle keeps peripherals, converter, timers, watchdog, interrupts running.
// R8: Idle accepts external and internal peripheral interrupt wake-ups.
// R9: Idle or quiet mode with converter enabled starts a conversion on entry.
// R10: Mode 001 gates peripheral, core and flash clocks.
// R11: Quiet mode wakes only on its listed converter, bus, timer, program, pin events.
// R12: Outside idle, ext_irq_2 and level ext_irq_1/0 wake in every mode; edges ignored.
// R13: Power-save and extended standby keep async timer only if async select set.
// R14: Standby modes only with crystal clock source; software must ensure that.
// R15: Main clock on in idle, quiet, standbys; off in power-down and power-save.
// R16: 010 power-down, 011 power-save, 110 standby, 111 extended standby.
// R17: Standby modes resume within six cycles of the wake event.
// R18: Wake is OR of qualified sources; gate enables change glitch-free.
// R19: Bus address-match wake honoured in every sleep mode.
module smc_sleep_ctrl (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [smc_pkg::ADDR_W-1:0]  adr_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  input  wire logic                        we_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  output logic                             ack_o,
  input  wire logic                        halt_exec_i,
  input  wire logic                        wake_reset_i,
  input  wire logic                        conv_enabled_i,
  input  wire logic                        crystal_sel_i,
  input  wire logic [smc_pkg::WK_N-1:0]    wake_src_i,
  output logic                             core_clk_en_o,
  output logic                             flash_clk_en_o,
  output logic                             periph_clk_en_o,
  output logic                             conv_clk_en_o,
  output logic                             async_clk_en_o,
  output logic                             main_osc_en_o,
  output logic                             timer_osc_en_o,
  output logic                             conv_start_o,
  output logic                             irq_resume_o,
  output logic                             reset_resume_o,
  output logic                             sleeping_o
);

  // Every output is a field of this one register, so each changes only on a clock edge
  typedef struct packed {
    logic [7:0]            ctrl;
    logic [7:0]            async_ctl;
    logic [15:0]           startup;
    smc_pkg::smc_state_type st;
    logic [2:0]            mode;
    logic [15:0]           cnt;
    logic                  ack;
    logic [31:0]           rdata;
    logic [6:0]            gates;
    logic                  conv_start;
    logic                  irq_resume;
    logic                  reset_resume;
    logic                  sleeping;
  } smc_regs_type;

  smc_regs_type r_reg;
  smc_regs_type r_next;

  // Clock enables for one mode: core, flash, periph, conv, async, main osc, timer osc
  function automatic logic [6:0] gate_decode(input logic [2:0] m, input logic async_sel);
    logic core_en;
    logic flash_en;
    logic periph_en;
    logic conv_en;
    logic async_en;
    logic main_en;
    logic tosc_en;
    // Core and flash stop in every sleep mode
    core_en   = 1'b0;
    flash_en  = 1'b0;
    periph_en = 1'b0;
    conv_en   = 1'b0;
    async_en  = 1'b0;
    main_en   = 1'b0;
    tosc_en   = 1'b0;
    case (m)
      smc_pkg::MODE_IDLE: begin
        periph_en = 1'b1;      // R6 R7
        conv_en   = 1'b1;      // R7
        async_en  = 1'b1;      // R6
        main_en   = 1'b1;      // R15
        tosc_en   = async_sel;
      end
      smc_pkg::MODE_QUIET: begin
        conv_en  = 1'b1;      // R10
        async_en = 1'b1;      // R10
        main_en  = 1'b1;      // R15
        tosc_en  = async_sel;
      end
      smc_pkg::MODE_PDOWN: begin
        main_en = 1'b0; // R16 R15
      end
      smc_pkg::MODE_PSAVE: begin
        async_en = async_sel; // R13
        tosc_en  = async_sel; // R13 R15
      end
      smc_pkg::MODE_STBY: begin
        main_en = 1'b1; // R16 R15
      end
      smc_pkg::MODE_XSTBY: begin
        async_en = async_sel; // R13
        main_en  = 1'b1;      // R15
        tosc_en  = async_sel; // R13
      end
      default: begin
        main_en = 1'b0;
      end
    endcase
    return {core_en, flash_en, periph_en, conv_en, async_en, main_en, tosc_en};
  endfunction : gate_decode

  // Wake sources qualified for a mode
  function automatic logic [smc_pkg::WK_N-1:0] wake_mask(input logic [2:0] m, input logic async_sel);
    logic [smc_pkg::WK_N-1:0] k;
    k = '0;
    k[smc_pkg::WK_EXT2]       = 1'b1; // R12
    k[smc_pkg::WK_EXT1_LVL]   = 1'b1; // R12
    k[smc_pkg::WK_EXT0_LVL]   = 1'b1; // R12
    k[smc_pkg::WK_ADDR_MATCH] = 1'b1; // R19
    case (m)
      smc_pkg::MODE_IDLE: k = '1; // R8
      smc_pkg::MODE_QUIET: begin
        k[smc_pkg::WK_TIMER2]    = 1'b1; // R11
        k[smc_pkg::WK_PROG_RDY]  = 1'b1; // R11
        k[smc_pkg::WK_CONV_DONE] = 1'b1; // R11
      end
      smc_pkg::MODE_PSAVE, smc_pkg::MODE_XSTBY: k[smc_pkg::WK_TIMER2] = async_sel; // R13
      smc_pkg::MODE_PDOWN, smc_pkg::MODE_STBY: begin
        // Timer 2 has no clock here, so its request cannot be trusted
        k[smc_pkg::WK_TIMER2] = 1'b0; // R16
      end
      default: k = k;
    endcase
    return k;
  endfunction : wake_mask

  // Views of the control and async words shared by both processes
  logic [2:0] mode_field;
  logic       async_sel;
  logic       mode_valid;
  logic       wake_any;
  logic [31:0] rd_mux;

  always_comb begin
    mode_field = {r_reg.ctrl[smc_pkg::CTRL_MODE_HI], r_reg.ctrl[smc_pkg::CTRL_MODE_MID],
                  r_reg.ctrl[smc_pkg::CTRL_MODE_LO]}; // R2
    async_sel  = r_reg.async_ctl[smc_pkg::ASYNC_SEL_BIT];
    // Unlisted codes and standby without a crystal are not entered
    mode_valid = (mode_field != 3'b100) && (mode_field != 3'b101) &&
                 (!mode_field[2] || crystal_sel_i); // R14
    wake_any   = |(wake_src_i & wake_mask(r_reg.mode, async_sel)); // R18
    case (adr_i)
      smc_pkg::OFF_CTRL:    rd_mux = {24'h00_0000, r_reg.ctrl};
      smc_pkg::OFF_ASYNC:   rd_mux = {24'h00_0000, r_reg.async_ctl};
      smc_pkg::OFF_STATUS:  rd_mux = {24'h00_0000, 1'b0, r_reg.gates};
      smc_pkg::OFF_STARTUP: rd_mux = {16'h0000, r_reg.startup};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    r_next              = r_reg;
    r_next.ack          = 1'b0;
    r_next.conv_start   = 1'b0;
    r_next.irq_resume   = 1'b0;
    r_next.reset_resume = 1'b0;
    // Bus: one registered ack a cycle after the strobe, dropped the cycle after it is given
    if (cyc_i && stb_i && !r_reg.ack) begin
      r_next.ack   = 1'b1;
      r_next.rdata = rd_mux;
      // Status is read-only; writes to it or to unmapped offsets are dropped
      if (we_i && sel_i[0]) begin
        case (adr_i)
          smc_pkg::OFF_CTRL:  r_next.ctrl      = dat_i[7:0];
          smc_pkg::OFF_ASYNC: r_next.async_ctl = dat_i[7:0];
          smc_pkg::OFF_STARTUP: r_next.startup[7:0] = dat_i[7:0];
          default: r_next.ctrl = r_next.ctrl;
        endcase
      end
      if (we_i && sel_i[1] && adr_i == smc_pkg::OFF_STARTUP) begin
        r_next.startup[15:8] = dat_i[15:8];
      end
    end
    case (r_reg.st)
      smc_pkg::SMC_AWAKE: begin
        // Mode is latched at entry; later control writes leave the gates alone
        r_next.gates    = 7'b111_1111;
        r_next.sleeping = 1'b0;
        if (halt_exec_i && r_reg.ctrl[smc_pkg::CTRL_ARM_BIT] && mode_valid) begin // R1
          r_next.st       = smc_pkg::SMC_ASLEEP;
          r_next.mode     = mode_field;
          r_next.gates    = gate_decode(mode_field, async_sel); // R18
          r_next.sleeping = 1'b1;
          // Sleep only stops clocks, storage is never touched
          r_next.conv_start = conv_enabled_i && !mode_field[2] && !mode_field[1]; // R9 R4
        end
      end
      smc_pkg::SMC_ASLEEP: begin
        // Decoded every cycle so a change of the async select acts during sleep
        r_next.gates = gate_decode(r_reg.mode, async_sel); // R13
        if (wake_reset_i) begin // R5
          r_next.st           = smc_pkg::SMC_AWAKE;
          r_next.gates        = 7'b111_1111;
          r_next.reset_resume = 1'b1;
          r_next.sleeping     = 1'b0;
        end else if (wake_any) begin
          r_next.st = smc_pkg::SMC_START;
          // Oscillator still running in idle, quiet and standbys
          if (r_reg.gates[1]) begin
            r_next.cnt = 16'(smc_pkg::HALT_EXTRA_CYC); // R3 R17
            r_next.st  = smc_pkg::SMC_HOLD;
          end else begin
            r_next.cnt = (r_reg.startup == 16'h0000) ? smc_pkg::CNT_ONE : r_reg.startup;
          end
          // Main oscillator and clocks other than core and flash restart first
          r_next.gates = {2'b00, 5'b1_1111};
        end
      end
      smc_pkg::SMC_START: begin
        // Counted start-up stands in for the stopped oscillator settling
        if (r_reg.cnt <= smc_pkg::CNT_ONE) begin
          r_next.st  = smc_pkg::SMC_HOLD;
          r_next.cnt = 16'(smc_pkg::HALT_EXTRA_CYC); // R3
        end else begin
          r_next.cnt = r_reg.cnt - smc_pkg::CNT_ONE;
        end
      end
      smc_pkg::SMC_HOLD: begin
        // Core and flash return together when the hold runs out
        if (r_reg.cnt <= smc_pkg::CNT_ONE) begin
          r_next.st    = smc_pkg::SMC_RESUME;
          r_next.gates = 7'b111_1111;
        end else begin
          r_next.cnt = r_reg.cnt - smc_pkg::CNT_ONE;
        end
      end
      smc_pkg::SMC_RESUME: begin
        r_next.st         = smc_pkg::SMC_AWAKE;
        r_next.irq_resume = 1'b1; // R3
        r_next.sleeping   = 1'b0;
      end
      default: r_next.st = smc_pkg::SMC_AWAKE;
    endcase
    // Reset still wins while the oscillator is starting; the core restarts from its vector
    if (wake_reset_i && r_reg.st != smc_pkg::SMC_AWAKE && r_reg.st != smc_pkg::SMC_ASLEEP) begin // R5
      r_next.st           = smc_pkg::SMC_AWAKE;
      r_next.gates        = 7'b111_1111;
      r_next.reset_resume = 1'b1;
      r_next.sleeping     = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg.ctrl         <= smc_pkg::CTRL_RESET;
      r_reg.async_ctl    <= smc_pkg::ASYNC_RESET;
      r_reg.startup      <= smc_pkg::STARTUP_RESET;
      r_reg.st           <= smc_pkg::SMC_AWAKE;
      r_reg.mode         <= smc_pkg::MODE_IDLE;
      r_reg.cnt          <= 16'h0000;
      r_reg.ack          <= 1'b0;
      r_reg.rdata        <= 32'h0000_0000;
      r_reg.gates        <= 7'b111_1111;
      r_reg.conv_start   <= 1'b0;
      r_reg.irq_resume   <= 1'b0;
      r_reg.reset_resume <= 1'b0;
      r_reg.sleeping     <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dat_o           = r_reg.rdata;
  assign ack_o           = r_reg.ack;
  assign core_clk_en_o   = r_reg.gates[6];
  assign flash_clk_en_o  = r_reg.gates[5];
  assign periph_clk_en_o = r_reg.gates[4];
  assign conv_clk_en_o   = r_reg.gates[3];
  assign async_clk_en_o  = r_reg.gates[2];
  assign main_osc_en_o   = r_reg.gates[1];
  assign timer_osc_en_o  = r_reg.gates[0];
  assign conv_start_o    = r_reg.conv_start;
  assign irq_resume_o    = r_reg.irq_resume;
  assign reset_resume_o  = r_reg.reset_resume;
  assign sleeping_o      = r_reg.sleeping;

endmodule : smc_sleep_ctrl
`default_nettype wire

// >>> pkg/smc_pkg.sv
// Purpose: Constants for the sleep-mode clock controller
// Assumes: 10 MHz system clock, classic Wishbone register access
// Notes:   Register byte offsets are word aligned
package smc_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_ASYNC     = 4'h4;
  localparam logic [3:0]  OFF_STATUS    = 4'h8;
  localparam logic [3:0]  OFF_STARTUP   = 4'hC;
  // Control word fields
  localparam int unsigned CTRL_ARM_BIT  = 6;
  localparam int unsigned CTRL_MODE_HI  = 7;
  localparam int unsigned CTRL_MODE_MID = 5;
  localparam int unsigned CTRL_MODE_LO  = 4;
  localparam int unsigned ASYNC_SEL_BIT = 3;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  ASYNC_RESET   = 8'h00;
  localparam logic [15:0] STARTUP_RESET = 16'h0006;
  // Mode encodings
  localparam logic [2:0]  MODE_IDLE     = 3'b000;
  localparam logic [2:0]  MODE_QUIET    = 3'b001;
  localparam logic [2:0]  MODE_PDOWN    = 3'b010;
  localparam logic [2:0]  MODE_PSAVE    = 3'b011;
  localparam logic [2:0]  MODE_STBY     = 3'b110;
  localparam logic [2:0]  MODE_XSTBY    = 3'b111;
  // Timing
  localparam int unsigned HALT_EXTRA_CYC = 4;
  localparam int unsigned STBY_WAKE_CYC  = 6;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  // Wake source vector positions
  localparam int unsigned WK_N          = 9;
  localparam int unsigned WK_EXT2       = 0;
  localparam int unsigned WK_EXT1_LVL   = 1;
  localparam int unsigned WK_EXT0_LVL   = 2;
  localparam int unsigned WK_EXT_EDGE   = 3;
  localparam int unsigned WK_ADDR_MATCH = 4;
  localparam int unsigned WK_TIMER2     = 5;
  localparam int unsigned WK_PROG_RDY   = 6;
  localparam int unsigned WK_CONV_DONE  = 7;
  localparam int unsigned WK_OTHER_IO   = 8;
  typedef enum logic [2:0] {
    SMC_AWAKE  = 3'b000,
    SMC_ASLEEP = 3'b001,
    SMC_START  = 3'b011,
    SMC_HOLD   = 3'b010,
    SMC_RESUME = 3'b110
  } smc_state_type;
endpackage : smc_pkg

// >>> test/smc_monitor.sv
// Purpose: Concurrent checks on sleep entry, gating and wake timing
// Assumes: Mode is shadowed from acknowledged control writes
// Notes:   Sees only the controller's ports
`timescale 1ns/1ps
`default_nettype none
module smc_monitor (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic [smc_pkg::ADDR_W-1:0] adr_i,
  input wire logic [31:0]               dat_i,
  input wire logic                      we_i,
  input wire logic                      cyc_i,
  input wire logic                      stb_i,
  input wire logic                      ack_o,
  input wire logic                      wake_reset_i,
  input wire logic                      conv_enabled_i,
  input wire logic [smc_pkg::WK_N-1:0]  wake_src_i,
  input wire logic                      core_clk_en_o,
  input wire logic                      periph_clk_en_o,
  input wire logic                      main_osc_en_o,
  input wire logic                      conv_start_o,
  input wire logic                      irq_resume_o,
  input wire logic                      reset_resume_o,
  input wire logic                      sleeping_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] ctl_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) ctl_reg <= 8'h00;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i == smc_pkg::OFF_CTRL) ctl_reg <= dat_i[7:0];
  end
  wire logic [2:0] mode = {ctl_reg[7], ctl_reg[5:4]};
  wire logic       idle = (mode == smc_pkg::MODE_IDLE);
  wire logic       addr_up = wake_src_i[smc_pkg::WK_ADDR_MATCH];
  arm_entry_a: assert property ($rose(sleeping_o) |-> ctl_reg[6])
    else $error("sleep entered while unarmed");
  idle_gates_a: assert property ($rose(sleeping_o) && idle |-> !core_clk_en_o && periph_clk_en_o)
    else $error("idle gating wrong");
  quiet_gates_a: assert property ($rose(sleeping_o) && mode == smc_pkg::MODE_QUIET |-> !periph_clk_en_o)
    else $error("quiet mode left peripheral clock on");
  main_osc_a: assert property ($rose(sleeping_o) |-> main_osc_en_o == (mode[2] || !mode[1]))
    else $error("main oscillator state wrong for mode");
  conv_kick_a: assert property ($rose(sleeping_o) && !mode[2] && !mode[1] && conv_enabled_i |-> conv_start_o)
    else $error("no conversion start on entry");
  conv_only_a: assert property (conv_start_o |-> $rose(sleeping_o) && !mode[2] && !mode[1] && conv_enabled_i)
    else $error("conversion start outside an enabled idle or quiet entry");
  core_hold_a: assert property (sleeping_o && main_osc_en_o && $rose(addr_up) |=> !core_clk_en_o [*4])
    else $error("core clock back too early");
  fast_wake_a: assert property (sleeping_o && main_osc_en_o && $rose(addr_up) |-> ##[1:6] irq_resume_o)
    else $error("running-oscillator wake too slow");
  edge_drop_a: assert property (sleeping_o && !idle && wake_src_i == 9'h008 && !wake_reset_i
    && !$past(wake_reset_i) |=> sleeping_o)
    else $error("edge request woke a deep mode");
  reset_wake_a: assert property (sleeping_o && wake_reset_i |-> ##[1:2] (reset_resume_o && core_clk_en_o))
    else $error("reset did not wake to vector");
  addr_wake_a: assert property (sleeping_o && $rose(addr_up) |-> ##[1:20] irq_resume_o)
    else $error("address match did not wake");
endmodule : smc_monitor
bind smc_sleep_ctrl smc_monitor u_mon (.clk_i, .rst_i, .adr_i, .dat_i, .we_i, .cyc_i, .stb_i, .ack_o,
  .wake_reset_i, .conv_enabled_i, .wake_src_i, .core_clk_en_o, .periph_clk_en_o, .main_osc_en_o,
  .conv_start_o, .irq_resume_o, .reset_resume_o, .sleeping_o);
`default_nettype wire

// >>> test/smc_core_model.sv
// Purpose: Core and interrupt-source stand-in facing the sleep controller
// Assumes: Requests arrive as one-cycle pulses from the bench
// Notes:   Wake sources stay up until a resume is seen, as a level interrupt
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       halt_req_i,
  input  wire logic [8:0] wake_req_i,
  input  wire logic       resumed_i,
  output logic            halt_exec_o,
  output logic [8:0]      wake_src_o
);
  always_ff @(posedge clk_i) begin
    halt_exec_o <= halt_req_i && !rst_i;
    if (rst_i || resumed_i) wake_src_o <= 9'h000;
    else wake_src_o <= wake_src_o | wake_req_i;
  end
endmodule : smc_core_model
`default_nettype wire

// >>> test/smc_sleep_ctrl_bench.sv
// Purpose: Register, entry, gating and wake sequences for the sleep controller
// Assumes: Conversion enabled except in one idle trial; crystal selected unless refused
// Notes:   Expected gate words are {core,flash,periph,conv,async,mainosc,timerosc}
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        halt_req = 1'b0;
  logic        wake_reset_i = 1'b0;
  logic        crystal_sel_i = 1'b1;
  logic        conv_enabled_i = 1'b1;
  logic [8:0]  wreq = 9'h000;
  logic [8:0]  wake_src_i;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o, halt_exec_i, irq_resume_o, reset_resume_o, sleeping_o;
  int          errors = 0;
  int          checks_done = 0;
  int          wake_cyc = 0;
  int          wake_exp = 0;
  logic [2:0]  md [7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b011, 3'b110, 3'b111};
  logic [7:0]  asy [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08};
  logic [6:0]  gate [7] = '{7'h1E, 7'h0E, 7'h00, 7'h00, 7'h05, 7'h02, 7'h07};
  smc_sleep_ctrl u_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i(4'hF), .cyc_i, .stb_i,
    .ack_o, .halt_exec_i, .wake_reset_i, .conv_enabled_i, .crystal_sel_i, .wake_src_i,
    .core_clk_en_o(), .flash_clk_en_o(), .periph_clk_en_o(), .conv_clk_en_o(), .async_clk_en_o(),
    .main_osc_en_o(), .timer_osc_en_o(), .conv_start_o(), .irq_resume_o, .reset_resume_o, .sleeping_o);
  smc_core_model u_core (.clk_i, .rst_i, .halt_req_i(halt_req), .wake_req_i(wreq),
    .resumed_i(irq_resume_o || reset_resume_o), .halt_exec_o(halt_exec_i), .wake_src_o(wake_src_i));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; read data is taken at the edge that samples ack
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h00_0000, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [3:0] a, input string nm, input logic [31:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic pulse(input logic h, input logic [8:0] v, input logic r);
    @(posedge clk_i);
    halt_req <= h;
    wreq <= v;
    wake_reset_i <= r;
    @(posedge clk_i);
    halt_req <= 1'b0;
    wreq <= 9'h000;
    wake_reset_i <= 1'b0;
  endtask : pulse
  task automatic nap(input logic want);
    while (sleeping_o !== want) @(posedge clk_i);
  endtask : nap
  // Sleep in mode c, offer sources v, then expect the state still to be asleep or not
  task automatic trial(input logic [7:0] c, input logic h, input logic [8:0] v, input logic e);
    wb(smc_pkg::OFF_CTRL, 1'b1, c);
    pulse(h, 9'h000, 1'b0);
    if (e) nap(1'b1);
    pulse(1'b0, v, 1'b0);
    repeat (12) @(posedge clk_i);
    chk("asleep", 32'(e), 32'(sleeping_o));
    if (sleeping_o === 1'b1) pulse(1'b0, 9'h000, 1'b1);
    nap(1'b0);
  endtask : trial
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(smc_pkg::OFF_CTRL, "ctrl", 32'(smc_pkg::CTRL_RESET));
    rdchk(smc_pkg::OFF_ASYNC, "async", 32'(smc_pkg::ASYNC_RESET));
    rdchk(smc_pkg::OFF_STARTUP, "startup", 32'(smc_pkg::STARTUP_RESET));
    wb(smc_pkg::OFF_STATUS, 1'b1, 8'h00);
    rdchk(smc_pkg::OFF_STATUS, "status", 32'h0000_007F);
    rdchk(4'h2, "unmapped", 32'h0000_0000);
    $display("registers done");
    for (int i = 0; i < 7; i++) begin
      wb(smc_pkg::OFF_ASYNC, 1'b1, asy[i]);
      wb(smc_pkg::OFF_CTRL, 1'b1, {md[i][2], 1'b1, md[i][1:0], 4'h0});
      pulse(1'b1, 9'h000, 1'b0);
      nap(1'b1);
      rdchk(smc_pkg::OFF_STATUS, "gates", 32'(gate[i]));
      pulse(1'b0, 9'h010, 1'b0);
      wake_cyc = 0;
      while (sleeping_o !== 1'b0) begin
        @(posedge clk_i);
        wake_cyc++;
      end
      // Source register, wake decode and resume step add three cycles
      wake_exp = (gate[i][1] ? 0 : smc_pkg::STARTUP_RESET) + smc_pkg::HALT_EXTRA_CYC + 3;
      chk("wake cycles", wake_exp, wake_cyc);
      rdchk(smc_pkg::OFF_STATUS, "woken", 32'h0000_007F);
      rdchk(smc_pkg::OFF_CTRL, "kept", {24'h00_0000, md[i][2], 1'b1, md[i][1:0], 4'h0});
      $display("mode %0d done", i);
    end
    trial(8'h00, 1'b1, 9'h000, 1'b0);
    crystal_sel_i <= 1'b0;
    trial(8'hE0, 1'b1, 9'h000, 1'b0);
    crystal_sel_i <= 1'b1;
    conv_enabled_i <= 1'b0;
    trial(8'h40, 1'b1, 9'h100, 1'b0);
    conv_enabled_i <= 1'b1;
    trial(8'h50, 1'b1, 9'h100, 1'b1);
    trial(8'h60, 1'b1, 9'h008, 1'b1);
    $display("refusals done");
    finish_test();
  end
endmodule : smc_sleep_ctrl_bench
`default_nettype wire
